// [flash_pkg.sv]
/*
 * Shared constants and types for the flash sequencer: register map,
 * control codes, commit target codes, reset values and timing.
 * Assumes a 32-bit AXI4-Lite register bus and a single 250 MHz clock.
 */
package flash_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_OFF   = 12'h000;
    localparam logic [11:0] DATA_OFF   = 12'h004;
    localparam logic [11:0] CTRL_OFF   = 12'h008;
    localparam logic [11:0] RAW_OFF    = 12'h00c;
    localparam logic [11:0] IMASK_OFF  = 12'h010;
    localparam logic [11:0] MSTAT_OFF  = 12'h014;
    localparam logic [11:0] RDWIN_OFF  = 12'h018;
    localparam logic [11:0] RDDAT_OFF  = 12'h01c;
    localparam logic [11:0] USEC_OFF   = 12'h140;
    localparam logic [11:0] DBG_OFF    = 12'h1d0;
    localparam logic [11:0] USER0_OFF  = 12'h1e0;
    localparam logic [11:0] USER1_OFF  = 12'h1e4;
    localparam logic [11:0] RE0_ALIAS  = 12'h130;
    localparam logic [11:0] PE0_ALIAS  = 12'h134;
    localparam logic [11:0] RE_BASE    = 12'h200;
    localparam logic [11:0] PE_BASE    = 12'h400;

    // ------------------------------------------------------------
    // Control register fields and key
    // ------------------------------------------------------------
    localparam logic [15:0] WRITE_KEY  = 16'ha442;
    localparam int          WR_BIT     = 0;
    localparam int          ER_BIT     = 1;
    localparam int          ME_BIT     = 2;
    localparam int          CM_BIT     = 3;
    localparam int          NW_BIT     = 31;

    // ------------------------------------------------------------
    // Commit target codes
    // ------------------------------------------------------------
    localparam logic [31:0] CM_RE0 = 32'h0000_0000;
    localparam logic [31:0] CM_RE1 = 32'h0000_0002;
    localparam logic [31:0] CM_RE2 = 32'h0000_0004;
    localparam logic [31:0] CM_RE3 = 32'h0000_0008;
    localparam logic [31:0] CM_PE0 = 32'h0000_0001;
    localparam logic [31:0] CM_PE1 = 32'h0000_0003;
    localparam logic [31:0] CM_PE2 = 32'h0000_0005;
    localparam logic [31:0] CM_PE3 = 32'h0000_0007;
    localparam logic [31:0] CM_US0 = 32'h8000_0000;
    localparam logic [31:0] CM_US1 = 32'h8000_0001;
    localparam logic [31:0] CM_DBG = 32'h7510_0000;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] ONES_RST   = 32'hffff_ffff;
    localparam logic [31:0] DBG_RST    = 32'hffff_fffe;
    localparam logic [7:0]  USEC_RST   = 8'h31;
    localparam logic [31:0] ERASED     = 32'hffff_ffff;

    // ------------------------------------------------------------
    // Timing, in microseconds of flash pulse
    // ------------------------------------------------------------
    localparam int PROG_US   = 20;
    localparam int ERASE_US  = 20;
    localparam int MASS_US   = 40;
    localparam int COMMIT_US = 20;
    localparam int CLK_MHZ   = 250;
    localparam int PROG_CYC  = PROG_US * CLK_MHZ;

    typedef enum logic [2:0] {
        OP_NONE, OP_PROG, OP_ERASE, OP_MASS, OP_COMMIT
    } op_type;

    typedef struct packed {
        logic        valid;
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } wreq_type;

endpackage

// [flash_ctrl.sv]
/*
 * Flash program, erase, commit and protection sequencer with an
 * AXI4-Lite register slave and a small register-modelled array.
 * Assumes one 250 MHz clock and a well-behaved AXI4-Lite master.
 */
// Notes on behaviour
// - Array is organised in 1 KB pages; erasing a page sets all bits.
// - Word program only clears bits; zeros stay zero.
// - Protection per 2 KB region; four pairs of 32-bit mask registers.
// - Pulse timing derives from reload value, which equals MHz minus one.
// - Program-enable zero keeps the region's contents unchanged.
// - Read-enable zero refuses data reads, returning all zeros.
// - Blocked program or erase raises fault interrupt when masked in.
// - Blocked data read raises a controller status flag.
// - All protection bits are one after factory default.
// - Protection writes act at once; power-on restores uncommitted clears.
// - Program: data, address, then key and write bit; bit clears at end.
// - Page erase: address, then key and erase bit; bit clears at end.
// - Mass erase: key and mass bit; bit clears when done.
// - Nonvolatile registers sit outside the array; erases leave them.
// - Commit starts on key and commit bit; address selects target.
// - Commit target codes select each mask and user word.
// - Debug word commit takes its data from the data register.
// - Committed bits only change one to zero.
// - User words lock on commit by clearing bit 31; debug word commits only while its bit 31 is set; power-on resets them.
// - Control writes without the key are ignored; key reads zero.
`timescale 1ns/1ps

module flash_ctrl #(
    parameter int WORDS    = 512,
    parameter int PROG_CNT = flash_pkg::PROG_CYC
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Power-on indication, high in the first cycle after power-up
    input  wire logic        por,
    // AXI4-Lite write address and data
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Access fault interrupt
    output logic             fault_irq
);

    localparam int AW = $clog2(WORDS);

    initial begin
        if (WORDS < 512 || (WORDS % 512) != 0 || WORDS > 65536)
            $error("WORDS must be a multiple of 512 up to 65536");
        if (PROG_CNT < 1)
            $error("PROG_CNT must be at least 1");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0]     array_ff [WORDS];
    logic [31:0]     addr_ff, data_ff, rdwin_ff, rddat_ff;
    logic [3:0]      ctrl_ff;
    logic [7:0]      usec_ff;
    logic [31:0]     re_ff [4];
    logic [31:0]     pe_ff [4];
    logic [31:0]     re_nv_ff [4] = '{default: flash_pkg::ONES_RST};
    logic [31:0]     pe_nv_ff [4] = '{default: flash_pkg::ONES_RST};
    logic [31:0]     user0_ff, user1_ff, dbg_ff;
    logic [1:0]      raw_ff;
    logic [1:0]      imask_ff;
    logic [7:0]      usec_cnt_ff;
    logic [15:0]     us_left_ff;
    flash_pkg::op_type op_ff;
    logic [AW-1:0]   mass_idx_ff;
    logic            awready_ff, wready_ff, bvalid_ff;
    logic            arready_ff, rvalid_ff;
    logic [31:0]     rdata_ff;
    logic            irq_ff;
    logic [11:0]     aw_ff;
    logic            aw_hold_ff, w_hold_ff;
    logic [31:0]     w_ff;

    // ------------------------------------------------------------
    // Write channel capture: address and data in either order
    // ------------------------------------------------------------
    wire aw_take = awvalid && awready_ff;
    wire w_take  = wvalid && wready_ff;
    wire [11:0] wa = aw_take ? awaddr : aw_ff;
    wire [31:0] wd = w_take ? wdata : w_ff;
    wire wr_go = (aw_take || aw_hold_ff) && (w_take || w_hold_ff)
                 && !bvalid_ff;
    wire [31:0] wm = {{8{wstrb[3]}}, {8{wstrb[2]}},
                      {8{wstrb[1]}}, {8{wstrb[0]}}};

    wire busy    = (op_ff != flash_pkg::OP_NONE);
    wire ctrl_wr = wr_go && wa == flash_pkg::CTRL_OFF;
    wire key_ok  = wd[31:16] == flash_pkg::WRITE_KEY;

    // ------------------------------------------------------------
    // Protection lookup
    // ------------------------------------------------------------
    // Region is the 2 KB block index: byte address bits 17:11.
    wire [6:0] reg_idx  = addr_ff[17:11];
    wire       pe_ok    = pe_ff[reg_idx[6:5]][reg_idx[4:0]];
    wire [6:0] rd_reg   = rdwin_ff[17:11];
    wire       re_ok    = re_ff[rd_reg[6:5]][rd_reg[4:0]];
    wire [AW-1:0] word_i = addr_ff[AW+1:2];
    wire [AW-1:0] rd_i   = rdwin_ff[AW+1:2];
    wire [AW-9:0] page_i = addr_ff[AW+1:10];

    // ------------------------------------------------------------
    // Microsecond tick from the reload value
    // ------------------------------------------------------------
    wire us_tick = busy && usec_cnt_ff == 8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn || !busy)
            usec_cnt_ff <= usec_ff;
        else if (us_tick)
            usec_cnt_ff <= usec_ff;
        else
            usec_cnt_ff <= usec_cnt_ff - 8'h01;
    end

    // ------------------------------------------------------------
    // Operation start decode
    // ------------------------------------------------------------
    wire start_ok = ctrl_wr && key_ok && !busy && wstrb[0];
    wire st_prog  = start_ok && wd[flash_pkg::WR_BIT];
    wire st_erase = start_ok && wd[flash_pkg::ER_BIT];
    wire st_mass  = start_ok && wd[flash_pkg::ME_BIT];
    wire st_comm  = start_ok && wd[flash_pkg::CM_BIT];
    wire blocked  = (st_prog || st_erase) && !pe_ok;
    wire mass_end = op_ff != flash_pkg::OP_MASS || mass_idx_ff == AW'(WORDS-1);
    wire done     = busy && us_tick && us_left_ff == 16'h0001 && mass_end;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            op_ff      <= flash_pkg::OP_NONE;
            ctrl_ff    <= 4'h0;
            us_left_ff <= 16'h0000;
        end else if (blocked) begin
            op_ff <= flash_pkg::OP_NONE;
        end else if (start_ok && wd[3:0] != 4'h0) begin
            ctrl_ff <= wd[3:0];
            if (st_prog) begin
                op_ff      <= flash_pkg::OP_PROG;
                us_left_ff <= 16'(flash_pkg::PROG_US);
            end else if (st_erase) begin
                op_ff      <= flash_pkg::OP_ERASE;
                us_left_ff <= 16'(flash_pkg::ERASE_US);
            end else if (st_mass) begin
                op_ff      <= flash_pkg::OP_MASS;
                us_left_ff <= 16'(flash_pkg::MASS_US);
            end else begin
                op_ff      <= flash_pkg::OP_COMMIT;
                us_left_ff <= 16'(flash_pkg::COMMIT_US);
            end
        end else if (done) begin
            op_ff   <= flash_pkg::OP_NONE;
            ctrl_ff <= 4'h0;
        end else if (us_tick && us_left_ff != 16'h0001) begin
            us_left_ff <= us_left_ff - 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Array: mass erase walks one word a cycle while the timer runs
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn)
            mass_idx_ff <= '0;
        else if (op_ff == flash_pkg::OP_MASS && mass_idx_ff != AW'(WORDS-1))
            mass_idx_ff <= mass_idx_ff + 1'b1;
        else if (!busy)
            mass_idx_ff <= '0;
    end

    wire [15:0] mass_w = 16'(mass_idx_ff);

    // The array is not reset: it is nonvolatile and only erases set it.
    always_ff @(posedge aclk) begin
        if (done && op_ff == flash_pkg::OP_PROG)
            array_ff[word_i] <= array_ff[word_i] & data_ff;
        if (op_ff == flash_pkg::OP_MASS && pe_ff[mass_w[15:14]][mass_w[13:9]])
            array_ff[mass_idx_ff] <= flash_pkg::ERASED;
        if (done && op_ff == flash_pkg::OP_ERASE)
            for (int i = 0; i < 256; i++)
                array_ff[{page_i, 8'(i)}] <= flash_pkg::ERASED;
    end

    // ------------------------------------------------------------
    // Nonvolatile registers and commit
    // ------------------------------------------------------------
    wire commit_done = done && op_ff == flash_pkg::OP_COMMIT;

    // Committed copies are nonvolatile, so no reset or power-on touches them.
    always @(posedge aclk) begin
        if (commit_done) begin
            case (addr_ff)
                flash_pkg::CM_RE0: re_nv_ff[0] <= re_nv_ff[0] & re_ff[0];
                flash_pkg::CM_RE1: re_nv_ff[1] <= re_nv_ff[1] & re_ff[1];
                flash_pkg::CM_RE2: re_nv_ff[2] <= re_nv_ff[2] & re_ff[2];
                flash_pkg::CM_RE3: re_nv_ff[3] <= re_nv_ff[3] & re_ff[3];
                flash_pkg::CM_PE0: pe_nv_ff[0] <= pe_nv_ff[0] & pe_ff[0];
                flash_pkg::CM_PE1: pe_nv_ff[1] <= pe_nv_ff[1] & pe_ff[1];
                flash_pkg::CM_PE2: pe_nv_ff[2] <= pe_nv_ff[2] & pe_ff[2];
                flash_pkg::CM_PE3: pe_nv_ff[3] <= pe_nv_ff[3] & pe_ff[3];
                default: ;
            endcase
        end
    end

    // Live masks: power-on reloads committed copies, so uncommitted
    // clears come back; a system reset keeps what software wrote.
    always_ff @(posedge aclk) begin
        if (por) begin
            for (int i = 0; i < 4; i++) begin
                re_ff[i] <= re_nv_ff[i];
                pe_ff[i] <= pe_nv_ff[i];
            end
            user0_ff <= flash_pkg::ONES_RST;
            user1_ff <= flash_pkg::ONES_RST;
            dbg_ff   <= flash_pkg::DBG_RST;
        end else if (wr_go) begin
            for (int i = 0; i < 4; i++) begin
                if (wa == flash_pkg::RE_BASE + 12'(4*i) ||
                    (i == 0 && wa == flash_pkg::RE0_ALIAS))
                    re_ff[i] <= (re_ff[i] & ~wm) | (wd & wm);
                if (wa == flash_pkg::PE_BASE + 12'(4*i) ||
                    (i == 0 && wa == flash_pkg::PE0_ALIAS))
                    pe_ff[i] <= (pe_ff[i] & ~wm) | (wd & wm);
            end
            if (wa == flash_pkg::USER0_OFF && user0_ff[flash_pkg::NW_BIT])
                user0_ff <= (user0_ff & ~wm) | (wd & wm);
            if (wa == flash_pkg::USER1_OFF && user1_ff[flash_pkg::NW_BIT])
                user1_ff <= (user1_ff & ~wm) | (wd & wm);
        end else if (commit_done) begin
            if (addr_ff == flash_pkg::CM_DBG && dbg_ff[flash_pkg::NW_BIT])
                dbg_ff <= dbg_ff & data_ff;
            if (addr_ff == flash_pkg::CM_US0)
                user0_ff[flash_pkg::NW_BIT] <= 1'b0;
            if (addr_ff == flash_pkg::CM_US1)
                user1_ff[flash_pkg::NW_BIT] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Plain registers
    // ------------------------------------------------------------
    wire rd_blk = wr_go && wa == flash_pkg::RDWIN_OFF;
    wire rd_bad = rd_blk && !(re_ff[wd[17:16]][wd[15:11]]);
    wire raw_clr_a = wr_go && wa == flash_pkg::MSTAT_OFF && wd[0];
    wire raw_clr_r = wr_go && wa == flash_pkg::MSTAT_OFF && wd[1];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_ff  <= 32'h0000_0000;
            data_ff  <= 32'h0000_0000;
            usec_ff  <= flash_pkg::USEC_RST;
            imask_ff <= 2'b00;
            raw_ff   <= 2'b00;
            rdwin_ff <= 32'h0000_0000;
            rddat_ff <= 32'h0000_0000;
        end else begin
            if (wr_go && wa == flash_pkg::ADDR_OFF)
                addr_ff <= wd;
            if (wr_go && wa == flash_pkg::DATA_OFF)
                data_ff <= wd;
            if (wr_go && wa == flash_pkg::USEC_OFF)
                usec_ff <= wd[7:0];
            if (wr_go && wa == flash_pkg::IMASK_OFF)
                imask_ff <= wd[1:0];
            if (rd_blk)
                rdwin_ff <= {14'h0000, wd[17:0]};
            rddat_ff <= re_ok ? array_ff[rd_i] : 32'h0000_0000;
            // Set wins over a same-cycle clear.
            raw_ff[0] <= blocked | (raw_ff[0] & ~raw_clr_a);
            raw_ff[1] <= rd_bad | (raw_ff[1] & ~raw_clr_r);
        end
    end

    // ------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            aw_ff      <= 12'h000;
            w_ff       <= 32'h0000_0000;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            irq_ff     <= 1'b0;
        end else begin
            if (aw_take) aw_ff <= awaddr;
            if (w_take)  w_ff  <= wdata;
            aw_hold_ff <= (aw_hold_ff || aw_take) && !wr_go;
            w_hold_ff  <= (w_hold_ff || w_take) && !wr_go;
            awready_ff <= !bvalid_ff && !wr_go && !aw_take && !aw_hold_ff;
            wready_ff  <= !bvalid_ff && !wr_go && !w_take && !w_hold_ff;
            bvalid_ff  <= wr_go || (bvalid_ff && !bready);
            irq_ff     <= |(raw_ff & imask_ff);
        end
    end

    wire [11:0] ra = araddr;
    wire [31:0] rd_mux =
        ra == flash_pkg::ADDR_OFF  ? addr_ff :
        ra == flash_pkg::DATA_OFF  ? data_ff :
        ra == flash_pkg::CTRL_OFF  ? {28'h0000000, ctrl_ff} :
        ra == flash_pkg::RAW_OFF   ? {30'h0, raw_ff} :
        ra == flash_pkg::IMASK_OFF ? {30'h0, imask_ff} :
        ra == flash_pkg::MSTAT_OFF ? {30'h0, raw_ff & imask_ff} :
        ra == flash_pkg::RDWIN_OFF ? rdwin_ff :
        ra == flash_pkg::RDDAT_OFF ? rddat_ff :
        ra == flash_pkg::USEC_OFF  ? {24'h0, usec_ff} :
        ra == flash_pkg::DBG_OFF   ? dbg_ff :
        ra == flash_pkg::USER0_OFF ? user0_ff :
        ra == flash_pkg::USER1_OFF ? user1_ff :
        ra == flash_pkg::RE0_ALIAS ? re_ff[0] :
        ra == flash_pkg::PE0_ALIAS ? pe_ff[0] :
        ra[11:4] == 8'h20          ? re_ff[ra[3:2]] :
        ra[11:4] == 8'h40          ? pe_ff[ra[3:2]] : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
        end else begin
            arready_ff <= !rvalid_ff && !(arvalid && arready_ff);
            if (arvalid && arready_ff) begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= rd_mux;
            end else if (rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    assign awready   = awready_ff;
    assign wready    = wready_ff;
    assign bvalid    = bvalid_ff;
    assign bresp     = 2'b00;
    assign arready   = arready_ff;
    assign rvalid    = rvalid_ff;
    assign rdata     = rdata_ff;
    assign rresp     = 2'b00;
    assign fault_irq = irq_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    prog_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_prog && pe_ok |=> ctrl_ff[0] && busy)
        else $error("write bit not set on program start");
    blocked_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        blocked |=> raw_ff[0] && !busy)
        else $error("blocked program did not flag fault");
    bad_key_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_wr && !key_ok && !busy |=> !busy)
        else $error("keyless control write started an operation");
    done_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        done |=> ctrl_ff == 4'h0)
        else $error("control bit not cleared at completion");
    usec_rst_a: assert property (@(posedge aclk)
        !aresetn |=> usec_ff == flash_pkg::USEC_RST)
        else $error("reload value default wrong");
    rd_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !re_ok |=> rddat_ff == 32'h0)
        else $error("protected read returned data");
    bus_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go |=> bvalid)
        else $error("write response missing");
    tick_a: assert property (@(posedge aclk) disable iff (!aresetn)
        us_tick && usec_ff != 8'h00 |=> !us_tick)
        else $error("microsecond tick too frequent");

endmodule

// [sw_master.sv]
/* Software side of the register bus: AXI4-Lite master tasks.
   Assumes one clock and a slave that answers in bounded time. */
`timescale 1ns/1ps
module sw_master (
    // Clock
    input  wire logic        aclk,
    // Write channels
    output logic [11:0]      awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic        bvalid,
    output logic             bready,
    // Read channels
    output logic [11:0]      araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic        rvalid,
    output logic             rready
);
    logic hung = 1'b0;
    initial {awaddr, awvalid, wdata, wvalid, bready} = '0;
    initial {araddr, arvalid, rready} = '0;
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int  n;
        bit  aw;
        bit  w;
        n = 0;
        aw = 1;
        w = 1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while ((aw || w) && n < 200) begin
            @(posedge aclk);
            n++;
            if (aw && awready) begin
                aw = 0;
                awvalid <= 1'b0;
            end
            if (w && wready) begin
                w = 0;
                wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge aclk);
            n++;
        end while (!bvalid && n < 200);
        if (n >= 200) hung = 1'b1;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (!arready && n < 200);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (!rvalid && n < 200);
        d = rdata;
        if (n >= 200) hung = 1'b1;
    endtask
endmodule

// [flash_program_protect_ctrl_tb.sv]
/* Self-checking bench for the flash sequencer over AXI4-Lite.
   Assumes the sequencer package and the sw_master partner model. */
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
    $display("Error t=%0t got=%h exp=%h", $time, (a), (e)); end end
module flash_program_protect_ctrl_tb;
    logic        aclk = 1'b0;
    logic        aresetn, por, fault_irq;
    logic [11:0] awaddr, araddr;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, v;
    int          n_errors = 0;
    int          checks = 0;
    flash_ctrl #(.WORDS(512)) flash_ctrl_inst (.aclk(aclk),
        .aresetn(aresetn), .por(por), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
        .wready(wready), .bresp(), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(), .rvalid(rvalid), .rready(rready),
        .fault_irq(fault_irq));
    sw_master sw_master_inst (.aclk(aclk), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rvalid(rvalid), .rready(rready));
    initial forever #2 aclk = ~aclk;
    task automatic close_out;
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge sw_master_inst.hung) begin
        n_errors++;
        close_out();
    end
    // Power-on reset: por for one cycle inside a 16-cycle reset.
    task automatic rst;
        aresetn <= 1'b0;
        por <= 1'b1;
        @(posedge aclk);
        por <= 1'b0;
        repeat (15) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        sw_master_inst.rd(a, v);
        `CHK(v, e)
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        sw_master_inst.wr(a, d);
    endtask
    task automatic arr(input logic [31:0] a, input logic [31:0] e);
        wr(flash_pkg::RDWIN_OFF, a[11:0]);
        rchk(flash_pkg::RDDAT_OFF, e);
    endtask
    // Start an operation; the first poll must show the expected busy bit.
    task automatic op(input logic [31:0] a, d, c, e);
        int n;
        wr(flash_pkg::DATA_OFF, d);
        wr(flash_pkg::ADDR_OFF, a[11:0]);
        wr(flash_pkg::CTRL_OFF, c);
        rchk(flash_pkg::CTRL_OFF, e);
        for (n = 0; n < 1000 && v !== 32'h0; n++)
            sw_master_inst.rd(flash_pkg::CTRL_OFF, v);
        if (n >= 1000) sw_master_inst.hung = 1'b1;
    endtask
    initial begin
        rst();
        rchk(flash_pkg::USEC_OFF, 32'h31);
        rchk(flash_pkg::RE_BASE + 12'h00c, 32'hffff_ffff);
        rchk(flash_pkg::PE_BASE + 12'h00c, 32'hffff_ffff);
        rchk(flash_pkg::DBG_OFF, 32'hffff_fffe);
        wr(flash_pkg::USEC_OFF, 32'h0);
        op(0, 0, 32'ha442_0004, 32'h4);
        arr(32'h7fc, 32'hffff_ffff);
        op(32'h10, 32'h1234_5678, 32'ha442_0001, 32'h1);
        arr(32'h10, 32'h1234_5678);
        op(32'h10, 32'hffff_00ff, 32'ha442_0001, 32'h1);
        arr(32'h10, 32'h1234_0078);
        op(32'h10, 0, 32'h1234_0001, 32'h0);
        op(32'h400, 0, 32'ha442_0002, 32'h2);
        arr(32'h10, 32'h1234_0078);
        op(32'h0, 0, 32'ha442_0002, 32'h2);
        arr(32'h10, 32'hffff_ffff);
        wr(flash_pkg::PE_BASE, 32'hffff_fffe);
        op(32'h20, 0, 32'ha442_0001, 32'h0);
        arr(32'h20, 32'hffff_ffff);
        rchk(flash_pkg::RAW_OFF, 32'h1);
        wr(flash_pkg::IMASK_OFF, 32'h1);
        repeat (2) @(posedge aclk);
        `CHK(fault_irq, 1'b1)
        wr(flash_pkg::RE_BASE, 32'hffff_fffe);
        arr(32'h20, 32'h0);
        rchk(flash_pkg::RAW_OFF, 32'h3);
        wr(flash_pkg::USEC_OFF, 32'h1);
        op(flash_pkg::CM_PE0, 0, 32'ha442_0008, 32'h8);
        rst();
        rchk(flash_pkg::RE_BASE, 32'hffff_ffff);
        rchk(flash_pkg::PE_BASE, 32'hffff_fffe);
        close_out();
    end
endmodule
